// *** common/mfr_status_pkg.sv ***
// Constants and carrier types for the vendor status byte and pad snapshot.
package mfr_status_pkg;
   localparam int NUM_CH = 4;
   localparam int PAGE_W = 2;

   // Status byte bit positions.
   localparam int ST_DISCHARGE = 7;
   localparam int ST_BUS_ONE   = 6;
   localparam int ST_BUS_ZERO  = 5;
   localparam int ST_SERVO     = 4;
   localparam int ST_DAC_CONN  = 3;
   localparam int ST_DAC_SAT   = 2;
   localparam int ST_AUX_REL   = 1;
   localparam int ST_WATCHDOG  = 0;

   // Pad snapshot bit positions.
   localparam int PAD_PWRGD_DRV = 15;
   localparam int PAD_ALERT_DRV = 14;
   localparam int PAD_FB0_DRV   = 13;
   localparam int PAD_FB1_DRV   = 12;
   localparam int PAD_RSV_MSB   = 11;
   localparam int PAD_RSV_LSB   = 10;
   localparam int PAD_ADDR_SELECT_PIN_ONE_LSB = 8;
   localparam int PAD_ADDR_SELECT_PIN_ZERO_LSB = 6;
   localparam int PAD_CTL1      = 5;
   localparam int PAD_CTL0      = 4;
   localparam int PAD_FB0       = 3;
   localparam int PAD_FB1       = 2;
   localparam int PAD_CTL2      = 1;
   localparam int PAD_CTL3      = 0;

   // Three-state address select codes; 2'h1 is never produced.
   localparam logic [1:0] ASEL_HIGH  = 2'h3;
   localparam logic [1:0] ASEL_FLOAT = 2'h2;
   localparam logic [1:0] ASEL_LOW   = 2'h0;

   // Read select codes.
   localparam logic SEL_STATUS = 1'h0;
   localparam logic SEL_PADS   = 1'h1;

   // Reset values.
   localparam logic [NUM_CH-1:0] FLAGS_RST = 4'h0;
   localparam logic [15:0]       RD_RST    = 16'h0000;
   localparam logic [9:0]        PINS_RST  = 10'h000;

   // Raw pad inputs, all asynchronous to the system clock.
   typedef struct packed {
      logic       fb_zero;
      logic       fb_one;
      logic [3:0] on_off;
      logic [1:0] asel_hi;
      logic [1:0] asel_lo;
   } pin_in_type;

   // Per-channel events and live levels from the channel logic.
   typedef struct packed {
      logic [NUM_CH-1:0] discharge;
      logic [NUM_CH-1:0] bus_one;
      logic [NUM_CH-1:0] bus_zero;
      logic [NUM_CH-1:0] servo_done;
      logic [NUM_CH-1:0] dac_limit;
      logic [NUM_CH-1:0] turn_on;
      logic [NUM_CH-1:0] servo_reached;
      logic [NUM_CH-1:0] dac_connected;
   } chan_evt_type;

   typedef struct packed {
      logic [NUM_CH-1:0] dis;
      logic [NUM_CH-1:0] fb1;
      logic [NUM_CH-1:0] fb0;
      logic [NUM_CH-1:0] sat;
      logic              wd;
      pin_in_type        s1;
      pin_in_type        s2;
      logic [15:0]       rd_data;
      logic              rd_valid;
      logic              alert_oe;
   } state_type;
endpackage

// *** hdl/mfr_status_pad_readback.sv ***
// Vendor status byte and raw pad snapshot with their sticky flags and alert drive.
module mfr_status_pad_readback
   import mfr_status_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   // Command read port
   input  wire logic              rd_req,
   input  wire logic              rd_sel,
   input  wire logic [PAGE_W-1:0] rd_page,
   output logic [15:0]            rd_data,
   output logic                   rd_valid,
   // Channel events and levels
   input  wire chan_evt_type      evt,
   input  wire logic              clear_faults,
   input  wire logic              watchdog_evt,
   input  wire logic              aux_released,
   // Pull-low requests of other pin drivers
   input  wire logic              pwrgd_pull_low,
   input  wire logic [1:0]        fault_bus_pull,
   // Raw pads
   input  wire pin_in_type        pins,
   // Alert open-drain pin
   output logic                   alert_pin_o,
   output logic                   alert_pin_oe
);

   state_type         state_r;
   state_type         state_nxt;
   logic              rst_s1_n;
   logic              rst_sync_n;
   logic [NUM_CH-1:0] clr;
   logic [15:0]       pads;
   logic [7:0]        status;

   // Floating wins when the detector reports both or neither.
   function automatic logic [1:0] asel_code(input logic hi, input logic lo);
      if (hi && !lo)
      begin
         return ASEL_HIGH;
      end
      else if (lo && !hi)
      begin
         return ASEL_LOW;
      end
      else
      begin
         return ASEL_FLOAT;
      end
   endfunction

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_s1_n   <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_s1_n   <= 1'b1;
         rst_sync_n <= rst_s1_n;
      end
   end

   // Turning a channel on also re-arms its sticky flags.
   assign clr = {NUM_CH{clear_faults}} | evt.turn_on;

   always_comb
   begin
      status                = 8'h00;
      status[ST_DISCHARGE]  = state_r.dis[rd_page];
      status[ST_BUS_ONE]    = state_r.fb1[rd_page];
      status[ST_BUS_ZERO]   = state_r.fb0[rd_page];
      status[ST_SERVO]      = evt.servo_reached[rd_page];
      status[ST_DAC_CONN]   = evt.dac_connected[rd_page];
      status[ST_DAC_SAT]    = state_r.sat[rd_page];
      status[ST_AUX_REL]    = aux_released;
      status[ST_WATCHDOG]   = state_r.wd;
   end

   // Pads are read after the synchroniser only; no deglitch filter is applied.
   always_comb
   begin
      pads                                    = 16'h0000;
      pads[PAD_PWRGD_DRV]                     = !pwrgd_pull_low;
      pads[PAD_ALERT_DRV]                     = !state_r.alert_oe;
      pads[PAD_FB0_DRV]                       = !fault_bus_pull[0];
      pads[PAD_FB1_DRV]                       = !fault_bus_pull[1];
      pads[PAD_ADDR_SELECT_PIN_ONE_LSB+1:PAD_ADDR_SELECT_PIN_ONE_LSB]     = asel_code(state_r.s2.asel_hi[1], state_r.s2.asel_lo[1]);
      pads[PAD_ADDR_SELECT_PIN_ZERO_LSB+1:PAD_ADDR_SELECT_PIN_ZERO_LSB]     = asel_code(state_r.s2.asel_hi[0], state_r.s2.asel_lo[0]);
      pads[PAD_CTL1]                          = state_r.s2.on_off[1];
      pads[PAD_CTL0]                          = state_r.s2.on_off[0];
      pads[PAD_CTL2]                          = state_r.s2.on_off[2];
      pads[PAD_CTL3]                          = state_r.s2.on_off[3];
      pads[PAD_FB0]                           = state_r.s2.fb_zero;
      pads[PAD_FB1]                           = state_r.s2.fb_one;
   end

   always_comb
   begin
      state_nxt    = state_r;
      state_nxt.s1 = pins;
      state_nxt.s2 = state_r.s1;
      // A new event in the clearing cycle survives the clear.
      state_nxt.dis = (state_r.dis & ~clr) | evt.discharge;
      state_nxt.fb1 = (state_r.fb1 & ~clr) | evt.bus_one;
      state_nxt.fb0 = (state_r.fb0 & ~clr) | evt.bus_zero;
      state_nxt.sat = (state_r.sat & ~clr) | (evt.servo_done & evt.dac_limit);
      state_nxt.wd  = (state_r.wd & !clear_faults) | watchdog_evt;
      // Drive follows the next discharge, bus and watchdog flags (not the saturation flag) so the pin falls with the flag.
      state_nxt.alert_oe = (|state_nxt.dis) | (|state_nxt.fb1) | (|state_nxt.fb0) | state_nxt.wd;
      state_nxt.rd_valid = rd_req;
      if (rd_req)
      begin
         if (rd_sel == SEL_PADS)
         begin
            state_nxt.rd_data = pads;
         end
         else
         begin
            state_nxt.rd_data = {8'h00, status};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         state_r.dis      <= FLAGS_RST;
         state_r.fb1      <= FLAGS_RST;
         state_r.fb0      <= FLAGS_RST;
         state_r.sat      <= FLAGS_RST;
         state_r.wd       <= 1'b0;
         state_r.s1       <= PINS_RST;
         state_r.s2       <= PINS_RST;
         state_r.rd_data  <= RD_RST;
         state_r.rd_valid <= 1'b0;
         state_r.alert_oe <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign rd_data      = state_r.rd_data;
   assign rd_valid     = state_r.rd_valid;
   assign alert_pin_o  = 1'b0;
   assign alert_pin_oe = state_r.alert_oe;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_sync_n);

   sequence s_wd_raised;
      watchdog_evt ##1 !clear_faults [*3];
   endsequence

   sequence s_pin_settle;
      pins.fb_zero ##1 pins.fb_zero ##1 (rd_req && rd_sel == SEL_PADS);
   endsequence

   property p_discharge_set;
      |evt.discharge |=> ((state_r.dis & $past(evt.discharge)) == $past(evt.discharge));
   endproperty
   a_discharge_set: assert property (p_discharge_set) else $error("discharge flag not set");

   property p_sticky_hold;
      (|state_r.fb1) && !clear_faults && evt.turn_on == 4'h0
         |=> ((state_r.fb1 & $past(state_r.fb1)) == $past(state_r.fb1));
   endproperty
   a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag dropped");

   property p_clear;
      clear_faults && evt.bus_zero == 4'h0 |=> state_r.fb0 == 4'h0;
   endproperty
   a_clear: assert property (p_clear) else $error("flag survived clear");

   property p_alert_follow;
      alert_pin_oe == ((|state_r.dis) | (|state_r.fb1) | (|state_r.fb0) | state_r.wd);
   endproperty
   a_alert_follow: assert property (p_alert_follow) else $error("alert drive mismatch");

   property p_wd_hold;
      s_wd_raised |-> state_r.wd && alert_pin_oe;
   endproperty
   a_wd_hold: assert property (p_wd_hold) else $error("watchdog flag lost");

   property p_status_wd;
      rd_req && rd_sel == SEL_STATUS
         |=> rd_valid && rd_data[ST_WATCHDOG] == $past(state_r.wd) && rd_data[15:8] == 8'h00;
   endproperty
   a_status_wd: assert property (p_status_wd) else $error("device-wide bit wrong");

   property p_pad_alert;
      rd_req && rd_sel == SEL_PADS |=> rd_data[PAD_ALERT_DRV] == !$past(alert_pin_oe);
   endproperty
   a_pad_alert: assert property (p_pad_alert) else $error("alert readback wrong");

   property p_pad_pwrgd;
      rd_req && rd_sel == SEL_PADS |=> rd_data[PAD_PWRGD_DRV] == !$past(pwrgd_pull_low);
   endproperty
   a_pad_pwrgd: assert property (p_pad_pwrgd) else $error("power-good readback wrong");

   property p_pad_reserved;
      rd_req && rd_sel == SEL_PADS |=> rd_data[PAD_RSV_MSB:PAD_RSV_LSB] == 2'h0
         && rd_data[PAD_ADDR_SELECT_PIN_ONE_LSB+1:PAD_ADDR_SELECT_PIN_ONE_LSB] != 2'h1 && rd_data[PAD_ADDR_SELECT_PIN_ZERO_LSB+1:PAD_ADDR_SELECT_PIN_ZERO_LSB] != 2'h1;
   endproperty
   a_pad_reserved: assert property (p_pad_reserved) else $error("reserved pad code seen");

   property p_pin_path;
      s_pin_settle |=> rd_data[PAD_FB0];
   endproperty
   a_pin_path: assert property (p_pin_path) else $error("pad level not sampled");

   property p_read_keeps;
      rd_req && !clear_faults && evt.turn_on == 4'h0
         |=> ((state_r.sat & $past(state_r.sat)) == $past(state_r.sat)) && (!$past(state_r.wd) || state_r.wd);
   endproperty
   a_read_keeps: assert property (p_read_keeps) else $error("read altered a flag");

endmodule

// *** testbench/mfr_status_and_pad_readback_bench.sv ***
// Self-checking bench for the vendor status byte and the pad snapshot.
module mfr_status_and_pad_readback_bench
   import mfr_status_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'h0, rstn = 1'h0, cf = 1'h0, wd = 1'h0, aux = 1'h0, pg = 1'h0;
   logic rd_req, rd_sel, rd_valid, alert_pin_o, alert_pin_oe;
   logic [1:0] fbp = 2'h0;
   logic [PAGE_W-1:0] rd_page;
   logic [15:0] rd_data;
   chan_evt_type ev = '0;
   pin_in_type pins = '0;
   int miscompares = 0, checked = 0;
   localparam logic [9:0] PV [4] = '{10'h2A5, 10'h153, 10'h0F6, 10'h30C};
   initial
   begin
      forever #2 clk_sys = ~clk_sys;
   end
   mfr_status_pad_readback i_dut (.clk_sys(clk_sys), .rstn(rstn), .rd_req(rd_req), .rd_sel(rd_sel),
      .rd_page(rd_page), .rd_data(rd_data), .rd_valid(rd_valid), .evt(ev), .clear_faults(cf),
      .watchdog_evt(wd), .aux_released(aux), .pwrgd_pull_low(pg), .fault_bus_pull(fbp), .pins(pins),
      .alert_pin_o(alert_pin_o), .alert_pin_oe(alert_pin_oe));
   status_host_model i_host (.clk_sys(clk_sys), .rd_req(rd_req), .rd_sel(rd_sel), .rd_page(rd_page),
      .rd_data(rd_data), .rd_valid(rd_valid));
   task report_and_stop();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task cmp16(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t read %h expected %h", $time, got, exp);
      end
   endtask
   // Alert drive is sampled mid-cycle, away from the edge that updates it.
   task cmp_alert(input logic exp);
      @(negedge clk_sys);
      checked++;
      if (alert_pin_oe !== exp || alert_pin_o !== 1'h0)
      begin
         miscompares++;
         $display("BAD %0t alert drive %b expected %b", $time, alert_pin_oe, exp);
      end
      @(posedge clk_sys);
   endtask
   task rd_chk(input logic sel, input logic [PAGE_W-1:0] page, input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      i_host.read(sel, page, d, ok);
      if (!ok)
      begin
         miscompares++;
         $display("BAD %0t no read answer", $time);
         report_and_stop();
      end
      else
      begin
         cmp16(d, exp);
      end
   endtask
   task pulse(input chan_evt_type e, input logic c, input logic w);
      ev <= e;
      cf <= c;
      wd <= w;
      @(posedge clk_sys);
      ev <= '0;
      cf <= 1'h0;
      wd <= 1'h0;
      @(posedge clk_sys);
   endtask
   function automatic logic [1:0] asel(input logic h, input logic l);
      return (h && !l) ? ASEL_HIGH : ((l && !h) ? ASEL_LOW : ASEL_FLOAT);
   endfunction
   function automatic logic [15:0] pad_exp(input pin_in_type p, input logic g, input logic [1:0] f, input logic a);
      return {~g, ~a, ~f[0], ~f[1], 2'h0, asel(p.asel_hi[1], p.asel_lo[1]), asel(p.asel_hi[0], p.asel_lo[0]),
              p.on_off[1], p.on_off[0], p.fb_zero, p.fb_one, p.on_off[2], p.on_off[3]};
   endfunction
   chan_evt_type e;
   logic [7:0] b;
   logic [15:0] pad_want;
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1'h1;
      repeat (4) @(posedge clk_sys);
      rd_chk(SEL_STATUS, 2'h0, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         pins <= pin_in_type'(PV[i]);
         pg <= i[0];
         fbp <= i[1:0];
         repeat (3) @(posedge clk_sys);
         pad_want = pad_exp(pin_in_type'(PV[i]), i[0], i[1:0], 1'h0);
         rd_chk(SEL_PADS, 2'h0, pad_want);
      end
      for (int k = 0; k < 4; k++)
      begin
         for (int c = 0; c < 4; c++)
         begin
            e = '0;
            case (k)
               0: e.discharge[c] = 1'h1;
               1: e.bus_one[c] = 1'h1;
               2: e.bus_zero[c] = 1'h1;
               default: {e.servo_done[c], e.dac_limit[c]} = 2'h3;
            endcase
            b = (k == 0) ? 8'h80 : (k == 1) ? 8'h40 : (k == 2) ? 8'h20 : 8'h04;
            pulse(e, 1'h0, 1'h0);
            for (int p = 0; p < 4; p++)
               rd_chk(SEL_STATUS, p[1:0], (p == c) ? {8'h00, b} : 16'h0000);
            cmp_alert(k != 3);
            e = '0;
            e.turn_on[(c + 1) % 4] = 1'h1;
            pulse(e, 1'h0, 1'h0);
            rd_chk(SEL_STATUS, c[1:0], {8'h00, b});
            e = '0;
            e.turn_on[c] = !c[0];
            pulse(e, c[0], 1'h0);
            rd_chk(SEL_STATUS, c[1:0], 16'h0000);
            cmp_alert(1'h0);
         end
      end
      e = '0;
      e.servo_done = 4'hF;
      pulse(e, 1'h0, 1'h0);
      e = '0;
      e.dac_limit = 4'hF;
      pulse(e, 1'h0, 1'h0);
      rd_chk(SEL_STATUS, 2'h1, 16'h0000);
      ev.servo_reached <= 4'h4;
      ev.dac_connected <= 4'h4;
      aux <= 1'h1;
      @(posedge clk_sys);
      rd_chk(SEL_STATUS, 2'h2, 16'h001A);
      rd_chk(SEL_STATUS, 2'h0, 16'h0002);
      cmp_alert(1'h0);
      pulse('0, 1'h0, 1'h0);
      aux <= 1'h0;
      pulse('0, 1'h0, 1'h1);
      rd_chk(SEL_STATUS, 2'h3, 16'h0001);
      cmp_alert(1'h1);
      rd_chk(SEL_PADS, 2'h0, pad_exp(pin_in_type'(PV[3]), 1'h1, 2'h3, 1'h1));
      e = '0;
      e.turn_on = 4'hF;
      pulse(e, 1'h0, 1'h0);
      rd_chk(SEL_STATUS, 2'h0, 16'h0001);
      pulse('0, 1'h1, 1'h0);
      rd_chk(SEL_STATUS, 2'h0, 16'h0000);
      cmp_alert(1'h0);
      // A reset in mid-run must drop a pending watchdog flag and release the alert pin.
      pulse('0, 1'h0, 1'h1);
      cmp_alert(1'h1);
      rstn <= 1'h0;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'h1;
      repeat (4) @(posedge clk_sys);
      rd_chk(SEL_STATUS, 2'h0, 16'h0000);
      cmp_alert(1'h0);
      report_and_stop();
   end
endmodule

// *** testbench/status_host_model.sv ***
// Host model that issues command reads to the status block and collects the answers.
module status_host_model
   import mfr_status_pkg::*;
(
   // Clock
   input  wire logic              clk_sys,
   // Read port toward the device
   output logic                   rd_req,
   output logic                   rd_sel,
   output logic [PAGE_W-1:0]      rd_page,
   input  wire logic [15:0]       rd_data,
   input  wire logic              rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      rd_req  = 1'h0;
      rd_sel  = SEL_STATUS;
      rd_page = '0;
   end
   // Entered just after a rising edge; select and page are inverted once released so stale values never help.
   task automatic read(input logic sel, input logic [PAGE_W-1:0] pg, output logic [15:0] d, output logic ok);
      ok = 1'h0;
      d = 16'h0000;
      rd_req  <= 1'h1;
      rd_sel  <= sel;
      rd_page <= pg;
      @(posedge clk_sys);
      rd_req  <= 1'h0;
      rd_sel  <= ~sel;
      rd_page <= ~pg;
      for (int n = 0; n < 4 && !ok; n++)
      begin
         @(negedge clk_sys);
         ok = (rd_valid === 1'h1);
         d = rd_data;
         @(posedge clk_sys);
      end
   endtask
endmodule
